//--- fep_pkg.sv
// Package of constants and types for the fine edge PWM extension
// Function
// - Split each clock period into fine steps
// - Fine step count from 8-bit duty or phase field
// - Extensions extend coarse phase and compare A
// - Duty extension at 0x10, shadowed loading
// - Phase extension at 0x4, written directly
// - Config at 0x1020, protected writes only
// - Write gate blocks config without permission
// - Edge mode: off, rising, falling or both
// - Control source: duty or phase extension
// - Shadow option only for duty source
// - Up to 255 fine step positions
// - Fine placement only from the 4th clock after period start
// - Coarse duty works down to zero early
// - Fine placement works in count-down mode
// - Step count from high byte, low ignored
// - Only channel A gets fine placement
package fep_pkg;
   // ***************************************************
   // Register map
   // ***************************************************
   localparam logic [15:0] FEP_OFF_PHASE = 16'h0004;
   localparam logic [15:0] FEP_OFF_DUTY = 16'h0010;
   localparam logic [15:0] FEP_OFF_CFG = 16'h1020;
   localparam logic [15:0] FEP_OFF_STATUS = 16'h1024;
   localparam logic [15:0] FEP_RST_PHASE = 16'h0000;
   localparam logic [15:0] FEP_RST_DUTY = 16'h0000;
   localparam logic [15:0] FEP_RST_CFG = 16'h0000;
   // ***************************************************
   // Config field positions
   // ***************************************************
   localparam int FEP_CFG_EDG_LO = 0;
   localparam int FEP_CFG_EDG_HI = 1;
   localparam int FEP_CFG_CTL = 2;
   localparam int FEP_CFG_SHD = 3;
   localparam int FEP_CFG_W = 4;
   localparam int FEP_EXT_HI = 15;
   localparam int FEP_EXT_LO = 8;
   // ***************************************************
   // Timing
   // ***************************************************
   localparam int FEP_CLK_PS = 4000;
   localparam int FEP_STEP_PS = 150;
   localparam int FEP_STEPS_PER_CLK = FEP_CLK_PS / FEP_STEP_PS;
   localparam logic [7:0] FEP_MAX_STEP = 8'hFF;
   localparam logic [1:0] FEP_HOLDOFF = 2'h3;
   // ***************************************************
   // Types
   // ***************************************************
   typedef enum logic [1:0] {
      FEP_EDGE_OFF = 2'b00,
      FEP_EDGE_RISE = 2'b01,
      FEP_EDGE_FALL = 2'b10,
      FEP_EDGE_BOTH = 2'b11
   } fep_edge_t;
   typedef struct packed {
      logic shadow;
      logic phase_src;
      fep_edge_t edge_mode;
   } fep_cfg_t;
   typedef struct packed {
      logic cnt_zero;
      logic cnt_prd;
      logic coarse_compare_a_load;
   } fep_tb_evt_t;
endpackage

//--- fep_delay.sv
// Behavioural sub-clock step delay for one edge
`timescale 1ns/1ps
module fep_delay
   import fep_pkg::*;
#(
   parameter int STEP_W = 8
) (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic ce,
   input wire logic edge_in,
   input wire logic [STEP_W-1:0] steps,
   output logic edge_out,
   output logic [STEP_W-1:0] steps_out
);
   // ***************************************************
   // Registered edge with step tag
   // ***************************************************
   // The analog delay line is outside; this carries the edge and its offset
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         edge_out <= 1'b0;
         steps_out <= '0;
      end else if (ce) begin
         edge_out <= edge_in;
         // Tag follows the qualified count so falling edges keep theirs too
         steps_out <= steps;
      end
   end
endmodule

//--- fep_top.sv
// Top of the fine edge PWM extension with APB registers
`timescale 1ns/1ps
module fep_top
   import fep_pkg::*;
#(
   parameter int EXT_W = 8
) (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic PROT_WR_EN,
   input wire logic CNT_DOWN,
   input wire logic [2:0] TB_EVT,
   input wire logic PWM_A_COARSE,
   input wire logic PWM_B_COARSE,
   output logic PWM_A_OUT,
   output logic [EXT_W-1:0] PWM_A_STEPS,
   output logic PWM_B_OUT,
   output logic [EXT_W-1:0] FINE_STEPS
);
   fep_tb_evt_t evt;
   fep_cfg_t cfg_reg;
   logic [15:0] phase_reg;
   logic [15:0] duty_act_reg;
   logic [15:0] duty_shd_reg;
   logic [1:0] since_start_reg;
   logic coarse_dly_reg;
   logic [31:0] rdata_next;
   logic wr_en;
   logic rd_en;
   logic hit;
   logic fine_ok;
   logic rise;
   logic fall;
   logic apply;
   logic [EXT_W-1:0] step_sel;
   logic [EXT_W-1:0] step_cap;
   logic [EXT_W-1:0] fine_steps_reg;

   assign evt = TB_EVT;

   // ***************************************************
   // APB decode
   // ***************************************************
   function automatic logic addr_known(input logic [15:0] a);
      addr_known = (a == FEP_OFF_PHASE) || (a == FEP_OFF_DUTY) ||
                   (a == FEP_OFF_CFG) || (a == FEP_OFF_STATUS);
   endfunction

   // Zero wait states; unmapped addresses flag an error
   assign PREADY = 1'b1;
   assign hit = addr_known(PADDR);
   assign PSLVERR = PSEL && PENABLE && !hit;
   assign wr_en = CE && PSEL && PENABLE && PWRITE && hit;
   assign rd_en = CE && PSEL && !PENABLE && !PWRITE;

   // ***************************************************
   // Registers
   // ***************************************************
   // Phase extension is written straight through
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         phase_reg <= FEP_RST_PHASE;
      end else if (wr_en && PADDR == FEP_OFF_PHASE) begin
         phase_reg <= PWDATA[15:0];
      end
   end

   // Duty extension, shadow copy takes software writes
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         duty_shd_reg <= FEP_RST_DUTY;
      end else if (wr_en && PADDR == FEP_OFF_DUTY) begin
         duty_shd_reg <= PWDATA[15:0];
      end
   end

   // Active duty: loaded at the compare load event when shadowed
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         duty_act_reg <= FEP_RST_DUTY;
      end else if (CE) begin
         if (cfg_reg.shadow && !cfg_reg.phase_src) begin
            if (evt.coarse_compare_a_load) begin
               duty_act_reg <= duty_shd_reg;
            end
         end else if (wr_en && PADDR == FEP_OFF_DUTY) begin
            duty_act_reg <= PWDATA[15:0];
         end else begin
            duty_act_reg <= duty_shd_reg;
         end
      end
   end

   // Config only changes while protected writes are permitted
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         cfg_reg <= FEP_RST_CFG[FEP_CFG_W-1:0];
      end else if (wr_en && PADDR == FEP_OFF_CFG && PROT_WR_EN) begin
         cfg_reg <= PWDATA[FEP_CFG_W-1:0];
      end
   end

   // Read mux, reserved bits zero
   always_comb begin
      rdata_next = 32'h0000_0000;
      unique case (PADDR)
         FEP_OFF_PHASE: rdata_next[15:0] = phase_reg;
         FEP_OFF_DUTY: rdata_next[15:0] = duty_shd_reg;
         FEP_OFF_CFG: rdata_next[FEP_CFG_W-1:0] = cfg_reg;
         FEP_OFF_STATUS: rdata_next[EXT_W+2:0] = {fine_steps_reg, fine_ok, since_start_reg};
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   // Read data registered in the setup cycle
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         PRDATA <= 32'h0000_0000;
      end else if (rd_en) begin
         PRDATA <= rdata_next;
      end
   end

   // ***************************************************
   // Period start holdoff
   // ***************************************************
   // Delay line needs three clocks to settle after each period start
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         since_start_reg <= 2'h0;
      end else if (CE) begin
         if (evt.cnt_zero || evt.cnt_prd) begin
            since_start_reg <= 2'h0;
         end else if (since_start_reg != FEP_HOLDOFF) begin
            since_start_reg <= since_start_reg + 2'h1;
         end
      end
   end
   assign fine_ok = (since_start_reg == FEP_HOLDOFF) && !(evt.cnt_zero || evt.cnt_prd);

   // ***************************************************
   // Edge selection and step source
   // ***************************************************
   // Step count is the high byte; low byte is the rounding part only
   assign step_sel = cfg_reg.phase_src ? phase_reg[FEP_EXT_HI:FEP_EXT_LO]
                                       : duty_act_reg[FEP_EXT_HI:FEP_EXT_LO];
   assign step_cap = (step_sel > FEP_MAX_STEP) ? FEP_MAX_STEP : step_sel;

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         coarse_dly_reg <= 1'b0;
      end else if (CE) begin
         coarse_dly_reg <= PWM_A_COARSE;
      end
   end
   assign rise = PWM_A_COARSE && !coarse_dly_reg;
   assign fall = !PWM_A_COARSE && coarse_dly_reg;

   // Count-down just flips which coarse edge comes first; rise mode still fine
   always_comb begin
      unique case (cfg_reg.edge_mode)
         FEP_EDGE_RISE: apply = rise;
         FEP_EDGE_FALL: apply = fall;
         FEP_EDGE_BOTH: apply = rise || fall;
         default: apply = 1'b0;
      endcase
   end

   // Early edges keep coarse timing so duty reaches zero
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         fine_steps_reg <= '0;
      end else if (CE && apply) begin
         fine_steps_reg <= fine_ok ? step_cap : '0;
      end
   end
   assign FINE_STEPS = fine_steps_reg;

   // ***************************************************
   // Channel outputs
   // ***************************************************
   fep_delay #(
      .STEP_W(EXT_W)
   ) u_delay (
      .CLK_SYS(CLK_SYS),
      .RSTN(RSTN),
      .ce(CE),
      .edge_in(PWM_A_COARSE),
      .steps((apply && fine_ok && !CNT_DOWN) || (apply && fine_ok && CNT_DOWN) ? step_cap : '0),
      .edge_out(PWM_A_OUT),
      .steps_out(PWM_A_STEPS)
   );

   // Channel B stays coarse, registered for equal latency
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         PWM_B_OUT <= 1'b0;
      end else if (CE) begin
         PWM_B_OUT <= PWM_B_COARSE;
      end
   end
endmodule

//--- fep_sva.sv
// Port checker for the fine edge PWM extension
`timescale 1ns/1ps
module fep_sva
   import fep_pkg::*;
#(
   parameter int EXT_W = 8
) (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic CE,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [15:0] PADDR,
   input wire logic [31:0] PRDATA,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic [2:0] TB_EVT,
   input wire logic PWM_A_COARSE,
   input wire logic PWM_B_COARSE,
   input wire logic PWM_A_OUT,
   input wire logic [EXT_W-1:0] PWM_A_STEPS,
   input wire logic PWM_B_OUT
);
   logic mapped;
   // Address decode of the four words
   assign mapped = PADDR inside {FEP_OFF_PHASE, FEP_OFF_DUTY, FEP_OFF_CFG, FEP_OFF_STATUS};
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   a_ready_high: assert property (PSEL |-> PREADY)
      else $error("ready low in transfer");
   a_err_unmapped: assert property (PSEL && PENABLE && !mapped |-> PSLVERR)
      else $error("no error on unmapped word");
   a_err_mapped: assert property (PSEL && PENABLE && mapped |-> !PSLVERR)
      else $error("error on mapped word");
   a_b_coarse: assert property (CE |=> PWM_B_OUT == $past(PWM_B_COARSE))
      else $error("channel B not one clock behind");
   a_a_coarse: assert property (CE |=> PWM_A_OUT == $past(PWM_A_COARSE))
      else $error("channel A not one clock behind");
   a_steps_edge: assert property (PWM_A_STEPS != 0 |-> PWM_A_OUT != $past(PWM_A_OUT))
      else $error("fine steps without an edge");
   a_start_holdoff: assert property (CE && (TB_EVT[2] || TB_EVT[1]) |=>
      (PWM_A_STEPS == 0) [*3]) else $error("fine steps early in period");
   a_rdata_hold: assert property (!(PSEL && !PENABLE && !PWRITE) |=> $stable(PRDATA))
      else $error("read data moved without read");
   // Main scenarios
   cover property (PSEL && PENABLE && PWRITE && PADDR == FEP_OFF_CFG);
   cover property (PWM_A_STEPS != 0);
   cover property (PSLVERR);
endmodule

//--- fep_switch_model.sv
// Power stage switch model counting gate transitions
`timescale 1ns/1ps
module fep_switch_model (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic gate_a,
   input wire logic [7:0] steps_a,
   input wire logic gate_b,
   output int sw_a_cnt,
   output int sw_b_cnt,
   output int fine_sum
);
   logic a_q;
   logic b_q;
   // Fine steps only stretch an edge inside its clock, so only their sum matters
   always @(posedge clk_sys) begin
      if (!rstn) begin
         sw_a_cnt <= 0;
         sw_b_cnt <= 0;
         fine_sum <= 0;
      end else begin
         sw_a_cnt <= sw_a_cnt + int'(gate_a !== a_q);
         sw_b_cnt <= sw_b_cnt + int'(gate_b !== b_q);
         fine_sum <= fine_sum + int'(steps_a);
      end
      a_q <= gate_a;
      b_q <= gate_b;
   end
endmodule

//--- fep_top_tb.sv
// Self-checking bench for the fine edge PWM extension
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fail_count++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module fep_top_tb;
   import fep_pkg::*;
   logic CLK_SYS = 1'b0, RSTN = 1'b0, CE = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
   logic PROT_WR_EN = 1'b0, CNT_DOWN = 1'b0, PWM_A_COARSE = 1'b0, PWM_B_COARSE = 1'b0;
   logic [15:0] PADDR = 16'h0000;
   logic [31:0] PWDATA = 32'h0000_0000;
   logic [2:0] TB_EVT = 3'h0;
   logic [31:0] PRDATA;
   logic PREADY, PSLVERR, PWM_A_OUT, PWM_B_OUT;
   logic [7:0] PWM_A_STEPS, FINE_STEPS;
   int fail_count = 0, checks_done = 0, exp_sum = 0, exp_sw = 0, sw_a, sw_b, fsum;
   fep_top #(.EXT_W(8)) i_fep_top (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE), .PSEL(PSEL),
      .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .PROT_WR_EN(PROT_WR_EN), .CNT_DOWN(CNT_DOWN),
      .TB_EVT(TB_EVT), .PWM_A_COARSE(PWM_A_COARSE), .PWM_B_COARSE(PWM_B_COARSE),
      .PWM_A_OUT(PWM_A_OUT), .PWM_A_STEPS(PWM_A_STEPS), .PWM_B_OUT(PWM_B_OUT),
      .FINE_STEPS(FINE_STEPS));
   fep_switch_model i_fep_switch_model (.clk_sys(CLK_SYS), .rstn(RSTN), .gate_a(PWM_A_OUT),
      .steps_a(PWM_A_STEPS), .gate_b(PWM_B_OUT), .sw_a_cnt(sw_a), .sw_b_cnt(sw_b),
      .fine_sum(fsum));
   // 250 MHz system clock
   always #2 CLK_SYS = ~CLK_SYS;
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // ****************************
   // Bus cycles
   // ****************************
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
      output logic [31:0] r);
      int n;
      @(posedge CLK_SYS);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK_SYS);
      PENABLE <= 1'b1;
      n = 0;
      // Bounded so a dead slave cannot hang the run
      do begin
         @(posedge CLK_SYS);
         n++;
      end while (PREADY !== 1'b1 && n < 16);
      if (PREADY !== 1'b1) begin
         fail_count++;
         final_report();
      end
      r = PRDATA;
      `CHK(PSLVERR, !(a inside {FEP_OFF_PHASE, FEP_OFF_DUTY, FEP_OFF_CFG, 16'h1024}))
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0000_0000, r);
      `CHK(r[15:0], e)
   endtask
   // Period start, then one coarse edge on both channels after d idle clocks
   task automatic edge_go(input logic v, input int d, input logic [7:0] n);
      @(posedge CLK_SYS);
      TB_EVT <= 3'b100;
      @(posedge CLK_SYS);
      TB_EVT <= 3'b000;
      repeat (d) @(posedge CLK_SYS);
      PWM_A_COARSE <= v;
      PWM_B_COARSE <= v;
      @(posedge CLK_SYS);
      #1;
      `CHK(PWM_A_OUT, v)
      `CHK(PWM_A_STEPS, n)
      if (n != 8'h00) `CHK(FINE_STEPS, n)
      exp_sum += int'(n);
      exp_sw++;
   endtask
   // ****************************
   // Scenarios
   // ****************************
   task automatic t_regs();
      rd(FEP_OFF_PHASE, FEP_RST_PHASE);
      rd(FEP_OFF_DUTY, FEP_RST_DUTY);
      rd(FEP_OFF_CFG, FEP_RST_CFG);
      wr(FEP_OFF_PHASE, 32'h0000_0B00);
      rd(FEP_OFF_PHASE, 16'h0B00);
      wr(FEP_OFF_CFG, 32'h0000_000F);
      rd(FEP_OFF_CFG, 16'h0000);
      rd(16'h0008, 16'h0000);
      $display("test regs done");
   endtask
   task automatic t_modes();
      logic [7:0] n;
      PROT_WR_EN <= 1'b1;
      CNT_DOWN <= 1'b1;
      wr(FEP_OFF_DUTY, 32'h0000_1680);
      for (int m = 1; m < 4; m++) begin
         n = (m == 3) ? 8'h0B : 8'h16;
         wr(FEP_OFF_CFG, 32'(m + 4 * int'(m == 3)));
         rd(FEP_OFF_CFG, 16'(m + 4 * int'(m == 3)));
         edge_go(1'b1, 4, m[0] ? n : 8'h00);
         edge_go(1'b0, 4, m[1] ? n : 8'h00);
      end
      edge_go(1'b1, 0, 8'h00);
      `CHK(FINE_STEPS, 8'h00)
      edge_go(1'b0, 4, 8'h0B);
      // Edge mode off: neither edge may carry fine steps
      wr(FEP_OFF_CFG, 32'h0000_0000);
      edge_go(1'b1, 4, 8'h00);
      edge_go(1'b0, 4, 8'h00);
      $display("test modes done");
   endtask
   task automatic t_shadow();
      wr(FEP_OFF_CFG, 32'h0000_0009);
      wr(FEP_OFF_DUTY, 32'h0000_3000);
      edge_go(1'b1, 4, 8'h16);
      edge_go(1'b0, 4, 8'h00);
      @(posedge CLK_SYS);
      TB_EVT <= 3'b001;
      edge_go(1'b1, 4, 8'h30);
      repeat (2) @(posedge CLK_SYS);
      #1;
      `CHK(sw_a, exp_sw)
      `CHK(sw_b, exp_sw)
      `CHK(fsum, exp_sum)
      // Status: last steps 0x30, window open, counter saturated at three
      rd(FEP_OFF_STATUS, 16'h0187);
      $display("test shadow done");
   endtask
   // Clock enable low freezes register writes and channel outputs
   task automatic t_freeze();
      CE <= 1'b0;
      wr(FEP_OFF_PHASE, 32'h0000_FF00);
      PWM_B_COARSE <= 1'b0;
      repeat (2) @(posedge CLK_SYS);
      #1;
      `CHK(PWM_B_OUT, 1'b1)
      @(posedge CLK_SYS);
      CE <= 1'b1;
      rd(FEP_OFF_PHASE, 16'h0B00);
      `CHK(PWM_B_OUT, 1'b0)
      $display("test freeze done");
   endtask
   initial begin
      repeat (2) @(posedge CLK_SYS);
      RSTN <= 1'b1;
      t_regs();
      t_modes();
      t_shadow();
      t_freeze();
      final_report();
   end
endmodule
bind fep_top fep_sva #(.EXT_W(EXT_W)) i_fep_sva (.CLK_SYS(CLK_SYS), .RSTN(RSTN), .CE(CE),
   .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .TB_EVT(TB_EVT), .PWM_A_COARSE(PWM_A_COARSE),
   .PWM_B_COARSE(PWM_B_COARSE), .PWM_A_OUT(PWM_A_OUT), .PWM_A_STEPS(PWM_A_STEPS),
   .PWM_B_OUT(PWM_B_OUT));
